// [src/lps_pkg.sv]
// Constants for the LCD power save sequencer
package lps_pkg;
  localparam logic [7:0] REG_POWER_SAVE_CONTROL = 8'h08;
  localparam int         PSE_BIT                = 0;
  localparam logic [7:0] PSC_RESET              = 8'h01;
  localparam logic [7:0] CMD_POWER_SAVE         = 8'h53;
  localparam logic [7:0] CMD_SYSTEM_CONFIGURE   = 8'h40;
  localparam logic [1:0] FRAMES_TO_DISABLE      = 2'h2;
  localparam int         SYS_CFG_PARAMS         = 8;
  localparam logic [3:0] SYS_CFG_PARAMS_W       = 4'h8;

  typedef enum logic [1:0]
  {
    ST_RUN      = 2'b00,
    ST_BLANKING = 2'b01,
    ST_SAVE     = 2'b10
  } lps_state_e;
endpackage

// [src/lps_power_save_sequencer.sv]
// Power save sequencer for a monochrome LCD controller
`timescale 1ns/1ns

module lps_power_save_sequencer
  import lps_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic       i_clock_enable,
  input  wire logic       i_reg_write,
  input  wire logic       i_reg_read,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_cmd_write,
  input  wire logic       i_cmd_is_param,
  input  wire logic [7:0] i_cmd_data,
  input  wire logic       i_frame_start,
  input  wire logic       i_frame_pulse,
  input  wire logic       i_line_pulse,
  input  wire logic       i_row_shift_clock,
  input  wire logic       i_ac_modulation,
  input  wire logic       i_col_chain_clock,
  input  wire logic       i_pixel_shift_clock,
  input  wire logic [3:0] i_panel_data,
  input  wire logic       i_col_driver_control,
  input  wire logic       i_mem_ctrl,
  input  wire logic       i_host_wait_n,
  input  wire logic [7:0] i_host_rdata,
  input  wire logic       i_host_rdata_en,
  output logic [7:0]      o_reg_rdata,
  output logic            o_power_save,
  output logic            o_clock_run,
  output logic            o_row_driver_disable,
  output logic            o_frame_pulse,
  output logic            o_line_pulse,
  output logic            o_row_shift_clock,
  output logic            o_lcd_ac_modulation,
  output logic            o_column_enable_chain_clock,
  output logic            o_pixel_shift_clock,
  output logic [3:0]      o_panel_data_out,
  output logic            o_column_driver_control,
  output logic            o_mem_ctrl,
  output logic            o_host_wait_n,
  output logic            o_host_wait_oe_n,
  output logic [7:0]      o_host_data_bus,
  output logic [7:0]      o_host_data_bus_oe_n
);

  lps_state_e state_q;
  lps_state_e state_d;
  logic [7:0] psc_q;
  logic [7:0] psc_d;
  logic [1:0] frames_q;
  logic [1:0] frames_d;
  logic [3:0] params_q;
  logic [3:0] params_d;
  logic       in_cfg_q;
  logic       in_cfg_d;
  logic [7:0] rdata_d;
  logic       cfg_p1;

  assign cfg_p1 = i_cmd_write && i_cmd_is_param && in_cfg_q
                  && (params_q == 4'h0);

  always_comb
  begin
    psc_d    = psc_q;
    in_cfg_d = in_cfg_q;
    params_d = params_q;
    rdata_d  = o_reg_rdata;
    if (i_reg_write && i_reg_addr == REG_POWER_SAVE_CONTROL)
    begin
      psc_d = i_reg_wdata;
    end
    if (i_cmd_write && !i_cmd_is_param)
    begin
      in_cfg_d = (i_cmd_data == CMD_SYSTEM_CONFIGURE);
      params_d = 4'h0;
      if (i_cmd_data == CMD_POWER_SAVE)
      begin
        psc_d[PSE_BIT] = 1'b1;
      end
    end
    else if (i_cmd_write && in_cfg_q)
    begin
      if (cfg_p1)
      begin
        psc_d[PSE_BIT] = 1'b0;
      end
      params_d = params_q + 4'h1;
      if (params_q == SYS_CFG_PARAMS_W - 4'h1)
      begin
        in_cfg_d = 1'b0;
      end
    end
    if (i_reg_read)
    begin
      rdata_d = (i_reg_addr == REG_POWER_SAVE_CONTROL) ? psc_q
                                                       : 8'h00;
    end
  end

  // Frames counted only while blanking; clocks keep running until save
  always_comb
  begin
    state_d  = state_q;
    frames_d = frames_q;
    case (state_q)
      ST_RUN:
      begin
        frames_d = 2'h0;
        if (psc_q[PSE_BIT])
        begin
          state_d = ST_BLANKING;
        end
      end
      ST_BLANKING:
      begin
        if (!psc_q[PSE_BIT])
        begin
          state_d = ST_RUN;
        end
        else if (i_frame_start)
        begin
          frames_d = frames_q + 2'h1;
          if (frames_q == FRAMES_TO_DISABLE - 2'h1)
          begin
            state_d = ST_SAVE;
          end
        end
      end
      ST_SAVE:
      begin
        if (!psc_q[PSE_BIT])
        begin
          state_d = ST_RUN;
        end
      end
      default:
      begin
        state_d = ST_SAVE;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_q     <= ST_SAVE;
      psc_q       <= PSC_RESET;
      frames_q    <= 2'h0;
      params_q    <= 4'h0;
      in_cfg_q    <= 1'b0;
      o_reg_rdata <= 8'h00;
    end
    else if (i_clock_enable)
    begin
      state_q     <= state_d;
      psc_q       <= psc_d;
      frames_q    <= frames_d;
      params_q    <= params_d;
      in_cfg_q    <= in_cfg_d;
      o_reg_rdata <= rdata_d;
    end
  end

  logic save_d;
  logic blank_d;
  assign save_d  = (state_d == ST_SAVE);
  assign blank_d = (state_d != ST_RUN) || psc_d[PSE_BIT];

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_power_save                <= 1'b1;
      o_clock_run                 <= 1'b0;
      o_row_driver_disable        <= 1'b0;
      o_frame_pulse               <= 1'b0;
      o_line_pulse                <= 1'b0;
      o_row_shift_clock           <= 1'b1;
      o_lcd_ac_modulation         <= 1'b0;
      o_column_enable_chain_clock <= 1'b0;
      o_pixel_shift_clock         <= 1'b0;
      o_panel_data_out            <= 4'h0;
      o_column_driver_control     <= 1'b1;
      o_mem_ctrl                  <= 1'b1;
      o_host_wait_n               <= 1'b1;
      o_host_wait_oe_n            <= 1'b1;
      o_host_data_bus             <= 8'h00;
      o_host_data_bus_oe_n        <= 8'hFF;
    end
    else if (i_clock_enable)
    begin
      o_power_save         <= save_d;
      o_clock_run          <= !save_d;
      o_row_driver_disable <= !save_d;
      o_panel_data_out     <= blank_d ? 4'h0 : i_panel_data;
      o_host_wait_n        <= i_host_wait_n;
      o_host_data_bus      <= i_host_rdata;
      if (save_d)
      begin
        o_frame_pulse               <= 1'b0;
        o_line_pulse                <= 1'b0;
        o_lcd_ac_modulation         <= 1'b0;
        o_column_enable_chain_clock <= 1'b0;
        o_pixel_shift_clock         <= 1'b0;
        o_row_shift_clock           <= 1'b1;
        o_column_driver_control     <= 1'b1;
        o_host_wait_oe_n            <= 1'b1;
        o_host_data_bus_oe_n        <= 8'hFF;
      end
      else
      begin
        o_frame_pulse               <= i_frame_pulse;
        o_line_pulse                <= i_line_pulse;
        o_lcd_ac_modulation         <= i_ac_modulation;
        o_column_enable_chain_clock <= i_col_chain_clock;
        o_pixel_shift_clock         <= i_pixel_shift_clock;
        o_row_shift_clock           <= i_row_shift_clock;
        o_column_driver_control     <= i_col_driver_control;
        o_mem_ctrl                  <= i_mem_ctrl;
        o_host_wait_oe_n            <= 1'b0;
        o_host_data_bus_oe_n        <= {8{!i_host_rdata_en}};
      end
    end
  end

  // Save output rises one edge after the frame boundary that ends blanking
  chk_enter_after_frame: assert property (
    @(posedge i_clock) disable iff (i_reset)
    ($rose(o_power_save) |-> $past(i_frame_start)))
    else $error("power save entered without frame boundary");
  chk_disable_low_save: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (o_power_save |-> !o_row_driver_disable && !o_pixel_shift_clock))
    else $error("row disable not low in save");
  chk_blank_data: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (o_power_save |-> o_panel_data_out == 4'h0))
    else $error("panel data not blank");
  chk_bus_floats: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (o_power_save |-> o_host_data_bus_oe_n == 8'hFF && o_host_wait_oe_n))
    else $error("host bus driven in save");
  chk_high_pins: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (o_power_save |-> o_row_shift_clock && o_column_driver_control))
    else $error("high pins wrong in save");
  // Save seen now means the last update already held memory control
  chk_mem_hold: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (o_power_save |-> $stable(o_mem_ctrl)))
    else $error("memory control moved in save");
  chk_exit_write: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (i_clock_enable && i_reg_write && i_reg_addr == REG_POWER_SAVE_CONTROL
     && !i_reg_wdata[PSE_BIT] ##1 i_clock_enable |=> !o_power_save))
    else $error("no exit after write");
  chk_cfg_exit: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (i_clock_enable && cfg_p1 && !(i_reg_write) |=> !psc_q[PSE_BIT]))
    else $error("configure did not clear enable");
  chk_clock_stop: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (o_power_save |-> !o_clock_run))
    else $error("clocks running in save");
  cov_enter: cover property (@(posedge i_clock) $rose(o_power_save));
  cov_exit: cover property (@(posedge i_clock) $fell(o_power_save));
  cov_cfg: cover property (@(posedge i_clock) cfg_p1);

endmodule // lps_power_save_sequencer

// [sim/lps_display_model.sv]
// Display engine model: frame timer and changing panel-side values
`timescale 1ns/1ns
module lps_display_model
#(
  parameter int FRAME_LEN = 13
)
(
  input  wire logic i_clock,
  input  wire logic i_reset,
  output logic      o_frame_start,
  output logic [7:0] o_pattern
);
  int unsigned cnt_q;

  // Pattern moves every cycle so a held output is told from a stale one
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      cnt_q     <= 0;
      o_pattern <= 8'h00;
    end
    else
    begin
      cnt_q     <= (cnt_q == FRAME_LEN - 1) ? 0 : cnt_q + 1;
      o_pattern <= o_pattern + 8'h01;
    end
  end

  assign o_frame_start = (cnt_q == 0) && !i_reset;
endmodule // lps_display_model

// [sim/test_lps_power_save_sequencer.sv]
// Self-checking bench for the power save sequencer
`timescale 1ns/1ns
module test_lps_power_save_sequencer
  import lps_pkg::*;
;
  localparam int F = 13;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       cw = 1'b0;
  logic       cp = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] cd = 8'h00;
  logic       fs;
  logic [7:0] p;
  logic [7:0] rdata;
  logic [7:0] db_oe_n;
  logic [4:0] lo;
  logic [3:0] pd;
  logic       ps;
  logic       run;
  logic       row_dis;
  logic       ce = 1'b1;
  logic       hw;
  logic [7:0] hdb;
  logic       rsc;
  logic       cdc;
  logic       mem;
  logic       w_oe_n;
  logic       m;
  int         n;
  int         error_cnt = 0;
  int         comparisons = 0;

  always #20 clk = ~clk;

  lps_display_model #(.FRAME_LEN(F)) model (.i_clock(clk), .i_reset(rst),
    .o_frame_start(fs), .o_pattern(p));

  lps_power_save_sequencer dut (.i_clock(clk), .i_reset(rst),
    .i_clock_enable(ce), .i_reg_write(wr), .i_reg_read(rd),
    .i_reg_addr(addr), .i_reg_wdata(wd), .i_cmd_write(cw),
    .i_cmd_is_param(cp), .i_cmd_data(cd), .i_frame_start(fs),
    .i_frame_pulse(p[0]), .i_line_pulse(p[1]), .i_row_shift_clock(p[2]),
    .i_ac_modulation(p[3]), .i_col_chain_clock(p[4]),
    .i_pixel_shift_clock(p[5]), .i_panel_data(p[7:4]),
    .i_col_driver_control(p[6]), .i_mem_ctrl(p[0]), .i_host_wait_n(p[7]),
    .i_host_rdata(p), .i_host_rdata_en(p[1]), .o_reg_rdata(rdata),
    .o_power_save(ps), .o_clock_run(run), .o_row_driver_disable(row_dis),
    .o_frame_pulse(lo[0]), .o_line_pulse(lo[1]),
    .o_row_shift_clock(rsc), .o_lcd_ac_modulation(lo[2]),
    .o_column_enable_chain_clock(lo[3]), .o_pixel_shift_clock(lo[4]),
    .o_panel_data_out(pd), .o_column_driver_control(cdc),
    .o_mem_ctrl(mem), .o_host_wait_n(hw), .o_host_wait_oe_n(w_oe_n),
    .o_host_data_bus(hdb), .o_host_data_bus_oe_n(db_oe_n));

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string s, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr   <= 1'b1;
    addr <= a;
    wd   <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read data", e, rdata);
  endtask

  task automatic cmd(input logic par, input logic [7:0] d);
    @(posedge clk);
    cw <= 1'b1;
    cp <= par;
    cd <= d;
    @(posedge clk);
    cw <= 1'b0;
  endtask

  function automatic logic pick(input int s);
    return (s == 0) ? row_dis : (s == 1) ? ps : (pd != 4'h0);
  endfunction

  // Bounded poll; blank checks panel data on every cycle of the wait after the first
  task automatic wait_for(input int s, input logic v, input int lim,
                          input bit blank, output int k);
    for (k = 1; k <= lim; k++)
    begin
      @(posedge clk);
      #1;
      if (blank && k > 1)
        chk("blank data", 8'h00, {4'h0, pd});
      if (pick(s) === v)
        return;
    end
    error_cnt++;
    $display("[ERR] wait %0d expected %b seen timeout", s, v);
    finish_test();
  endtask

  task automatic check_save();
    chk("power save", 8'h01, {7'h0, ps});
    chk("clock run", 8'h00, {7'h0, run});
    chk("row disable", 8'h00, {7'h0, row_dis});
    chk("low pins", 8'h00, {3'h0, lo});
    chk("panel data", 8'h00, {4'h0, pd});
    chk("high pins", 8'h03, {6'h0, rsc, cdc});
    chk("bus oe_n", 8'hff, db_oe_n);
    chk("wait oe_n", 8'h01, {7'h0, w_oe_n});
  endtask

  // Outputs follow the engine one edge late: expect the previous pattern
  task automatic check_run();
    logic [7:0] q;
    q = p - 8'h01;
    chk("run low pins", {3'h0, q[5:3], q[1:0]}, {3'h0, lo});
    chk("run panel data", {4'h0, q[7:4]}, {4'h0, pd});
    chk("run high pins", {6'h0, q[2], q[6]}, {6'h0, rsc, cdc});
    chk("run memory control", {7'h0, q[0]}, {7'h0, mem});
    chk("run wait", {7'h0, q[7]}, {7'h0, hw});
    chk("run host data", q, hdb);
    chk("run bus oe_n", {8{!q[1]}}, db_oe_n);
    chk("run wait oe_n", 8'h00, {7'h0, w_oe_n});
  endtask

  task automatic leave_by_reg(input logic [7:0] dummy);
    reg_wr(REG_POWER_SAVE_CONTROL, 8'h00);
    reg_wr(dummy, 8'h00);
    wait_for(1, 1'b0, 4, 1'b0, n);
    chk("run row disable", 8'h01, {7'h0, row_dis});
    chk("run clock", 8'h01, {7'h0, run});
    check_run();
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check_save();
    reg_rd(REG_POWER_SAVE_CONTROL, PSC_RESET);
    $display("test reset state done");
    leave_by_reg(8'h00);
    wait_for(2, 1'b1, 40, 1'b0, n);
    reg_rd(REG_POWER_SAVE_CONTROL, 8'h00);
    reg_rd(8'h3c, 8'h00);
    $display("test register exit done");
    reg_wr(REG_POWER_SAVE_CONTROL, 8'h01);
    wait_for(0, 1'b0, 3 * F, 1'b1, n);
    chk("row delay", 8'h01, {7'h0, (n >= F && n <= 2 * F)});
    check_save();
    m = mem;
    repeat (3) @(posedge clk);
    #1;
    chk("memory control", {7'h0, m}, {7'h0, mem});
    // A write offered while the clock enable is low must be lost
    @(posedge clk);
    ce <= 1'b0;
    reg_wr(REG_POWER_SAVE_CONTROL, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    #1;
    chk("frozen save", 8'h01, {7'h0, ps});
    reg_rd(REG_POWER_SAVE_CONTROL, 8'h01);
    $display("test register entry done");
    leave_by_reg(8'h10);
    // Drive supplies taken as already off before the command
    cmd(1'b0, CMD_POWER_SAVE);
    wait_for(0, 1'b0, 3 * F, 1'b1, n);
    chk("cmd delay", 8'h01, {7'h0, (n >= F && n <= 2 * F)});
    check_save();
    cmd(1'b0, CMD_SYSTEM_CONFIGURE);
    cmd(1'b1, 8'h30);
    wait_for(1, 1'b0, 4, 1'b0, n);
    reg_rd(REG_POWER_SAVE_CONTROL, 8'h00);
    for (int i = 1; i < SYS_CFG_PARAMS; i++)
      cmd(1'b1, 8'h00);
    #1;
    chk("after params", 8'h00, {7'h0, ps});
    check_run();
    $display("test command path done");
    finish_test();
  end
endmodule // test_lps_power_save_sequencer
